/* hdl/igc_consts.svh */
// Purpose: offsets, field positions, reset values and counts of the
//          global configuration and feature block
// Assumes: 18-bit byte addresses on the register bus
// Notes:   definitions only
`ifndef IGC_CONSTS_SVH
`define IGC_CONSTS_SVH

// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define IGC_ADDR_W          18
`define IGC_OFF_FEATURE     18'h01000
`define IGC_OFF_GLOBAL_CFG  18'h01020
`define IGC_OFF_SRC0_VP     18'h10000
`define IGC_OFF_SRC0_DEST   18'h10010
`define IGC_OFF_CPU0_INTERRUPT_ACKNOWLEDGE   18'h200A0
`define IGC_OFF_CPU0_EOI    18'h200B0
`define IGC_OFF_CPU1_INTERRUPT_ACKNOWLEDGE   18'h210A0
`define IGC_OFF_CPU1_EOI    18'h210B0

// ----------------------------------------------------------------------
// feature report fields
// ----------------------------------------------------------------------
`define IGC_FR_SRC_LSB      16
`define IGC_FR_SRC_W        11
`define IGC_FR_CPU_LSB      8
`define IGC_FR_CPU_W        5
`define IGC_FR_VER_W        8
`define IGC_SPEC_VERSION    8'h02
`define IGC_NUM_SOURCES     16
`define IGC_NUM_CPUS        2

// ----------------------------------------------------------------------
// global configuration fields
// ----------------------------------------------------------------------
`define IGC_GC_RESET_BIT    31
`define IGC_GC_MODE_BIT     29

// ----------------------------------------------------------------------
// source 0 vector/priority and destination fields
// ----------------------------------------------------------------------
`define IGC_VP_MASK_BIT     31
`define IGC_VP_PRIO_LSB     16
`define IGC_VP_PRIO_W       4
`define IGC_VP_VEC_W        8
`define IGC_VP_MASK_RST     1'h1
`define IGC_VP_PRIO_RST     4'h0
`define IGC_VP_VEC_RST      8'h00
`define IGC_DEST_RST        2'h0
`define IGC_SPURIOUS_VEC    8'hFF

// ----------------------------------------------------------------------
// soft reset sequence
// ----------------------------------------------------------------------
`define IGC_RST_CNT_W       8
`define IGC_RST_CYCLES      8

`endif

/* hdl/igc_delivery.sv */
// Purpose: delivers the cascaded source 0 request to the processors
// Assumes: source input is a level, synchronous to the clock
// Notes:   one in-service flag per processor, set by acknowledge
`include "igc_consts.svh"
`default_nettype none

module igc_delivery (
  input  wire logic  i_clk,
  input  wire logic  i_rst_n,
  igc_dlv_if.dlv     bus
);

  igc_pkg::igc_dlv_st_t q_reg;
  igc_pkg::igc_dlv_st_t q_next;

  // --------------------------------------------------------------------
  // next state
  // --------------------------------------------------------------------
  // priority gate, destination fan-out, in-service hold
  always_comb begin
    logic live;
    live   = 1'b0;
    q_next = q_reg;
    live   = bus.src && !bus.mask && (bus.prio != `IGC_VP_PRIO_RST); // R6
    for (int n = 0; n < `IGC_NUM_CPUS; n++) begin
      if (bus.interrupt_completion[n]) begin
        q_next.in_svc[n] = 1'b0;
      end
      if (bus.ack[n] && q_reg.cpu_int[n]) begin
        q_next.in_svc[n] = 1'b1; // acknowledge wins over completion
      end
      q_next.cpu_int[n] = live && bus.dest[n] && !q_next.in_svc[n]; // R7
    end
    if (bus.soft_rst) begin
      q_next = '0; // R1
    end
  end

  // --------------------------------------------------------------------
  // state register
  // --------------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      q_reg <= '0;
    end else begin
      q_reg <= q_next;
    end
  end

  assign bus.cpu_int = q_reg.cpu_int;

  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  a_src_zero_delivered: assert property ( // R4
    bus.src && !bus.mask && bus.prio != 0 && bus.dest[1] && !bus.soft_rst
    && !q_reg.in_svc[1] && !bus.ack[1] |=> q_reg.cpu_int[1])
    else $error("source 0 request not delivered to processor 1");
  a_dest_gates_int: assert property ( // R7
    !bus.dest[0] || bus.mask |=> !q_reg.cpu_int[0])
    else $error("interrupt raised without destination or while masked");
  a_soft_rst_clears: assert property ( // R1
    bus.soft_rst |=> q_reg.cpu_int == 0 && q_reg.in_svc == 0)
    else $error("delivery state survives controller reset");

endmodule

`default_nettype wire

/* hdl/igc_dlv_if.sv */
// Purpose: carrier between register file and source 0 delivery
// Assumes: single clock domain
// Notes:   ctl side is the register file, dlv side the delivery logic
`include "igc_consts.svh"
`default_nettype none

interface igc_dlv_if;
  logic                          soft_rst;
  logic                          src;
  logic [`IGC_VP_PRIO_W-1:0]     prio;
  logic                          mask;
  logic [`IGC_NUM_CPUS-1:0]      dest;
  logic [`IGC_NUM_CPUS-1:0]      ack;
  logic [`IGC_NUM_CPUS-1:0]      interrupt_completion;
  logic [`IGC_NUM_CPUS-1:0]      cpu_int;

  modport ctl (output soft_rst, src, prio, mask, dest, ack, interrupt_completion,
               input  cpu_int);
  modport dlv (input  soft_rst, src, prio, mask, dest, ack, interrupt_completion,
               output cpu_int);
endinterface

`default_nettype wire

/* hdl/igc_pkg.sv */
// Purpose: types shared by the global configuration block
// Assumes: constants come from igc_consts.svh
// Notes:   state of each module is one packed struct, except the reset release flops of igc_top
`include "igc_consts.svh"
`default_nettype none

package igc_pkg;

  // soft reset sequencer, one-hot
  typedef enum logic [1:0] {
    IGC_RUN = 2'b01,
    IGC_CLR = 2'b10
  } igc_rst_state_t;

  // register file and bus slave state
  typedef struct packed {
    logic                        pready;
    logic                        pslverr;
    logic [31:0]                 prdata;
    igc_rst_state_t              rst_state;
    logic [`IGC_RST_CNT_W-1:0]   rst_cnt;
    logic [`IGC_VP_VEC_W-1:0]    vector;
    logic [`IGC_VP_PRIO_W-1:0]   prio;
    logic                        mask;
    logic [`IGC_NUM_CPUS-1:0]    dest;
  } igc_main_st_t;

  // delivery state
  typedef struct packed {
    logic [`IGC_NUM_CPUS-1:0]    in_svc;
    logic [`IGC_NUM_CPUS-1:0]    cpu_int;
  } igc_dlv_st_t;

endpackage

`default_nettype wire

/* hdl/igc_top.sv */
// Purpose: global configuration, feature report and processor
//          acknowledge/completion registers behind an APB slave
// Assumes: APB master holds each request until pready is seen
// Notes:   zero-wait slave, one access cycle per transfer
//
// Function
// R1: writing reset bit resets all controller logic
// R2: reset bit clears itself when sequence ends
// R3: software ignores other registers during reset
// R4: cascaded external pair enters on source zero
// R5: cascade mode bit always reads one
// R6: cascaded requests use normal priority and distribution
// R7: source zero settings govern all cascaded interrupts
// R8: version field reads fixed specification level
// R9: read-only feature word reports sources, processors
// R10: unused bits read zero, ignore writes
//
// Chosen here: register access over APB.
`include "igc_consts.svh"
`default_nettype none

module igc_top #(
  parameter int unsigned                   NUM_SOURCES = `IGC_NUM_SOURCES,
  parameter int unsigned                   NUM_CPUS    = `IGC_NUM_CPUS,
  parameter logic [`IGC_RST_CNT_W-1:0]     RST_CYCLES  = `IGC_RST_CYCLES
) (
  input  wire logic                        i_sys_clk,
  input  wire logic                        i_arst_n,
  input  wire logic                        i_psel,
  input  wire logic                        i_penable,
  input  wire logic                        i_pwrite,
  input  wire logic [`IGC_ADDR_W-1:0]      i_paddr,
  input  wire logic [31:0]                 i_pwdata,
  input  wire logic                        i_src0_irq,
  output logic                             o_pready,
  output logic                             o_pslverr,
  output logic [31:0]                      o_prdata,
  output logic [`IGC_NUM_CPUS-1:0]         o_cpu_int,
  output logic                             o_ctrl_in_reset
);

  // --------------------------------------------------------------------
  // reset release
  // --------------------------------------------------------------------
  logic [1:0] rst_sync_reg;
  logic       rst_n;

  // two flops release the asynchronous reset on the clock
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rst_sync_reg <= 2'h0;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_reg[1];

  // --------------------------------------------------------------------
  // address decode and read values
  // --------------------------------------------------------------------
  function automatic logic hit(input logic [`IGC_ADDR_W-1:0] a,
                               input logic [`IGC_ADDR_W-1:0] off);
    hit = (a == off);
  endfunction

  localparam logic [`IGC_FR_SRC_W-1:0] SRC_FIELD =
    `IGC_FR_SRC_W'(NUM_SOURCES - 1);
  localparam logic [`IGC_FR_CPU_W-1:0] CPU_FIELD =
    `IGC_FR_CPU_W'(NUM_CPUS - 1);

  // fixed feature word, upper and gap bits zero
  localparam logic [31:0] FEATURE_WORD =
    (32'(SRC_FIELD) << `IGC_FR_SRC_LSB) |
    (32'(CPU_FIELD) << `IGC_FR_CPU_LSB) |
    32'(`IGC_SPEC_VERSION); // R8 R9

  igc_pkg::igc_main_st_t q_reg;
  igc_pkg::igc_main_st_t q_next;
  igc_dlv_if             dlv_bus ();

  logic setup;
  logic done;
  assign setup = i_psel && !i_penable;
  assign done  = i_psel && i_penable && q_reg.pready;

  // --------------------------------------------------------------------
  // next state: bus slave, soft reset sequence, source 0 settings
  // --------------------------------------------------------------------
  always_comb begin
    q_next         = q_reg;
    q_next.pready  = 1'b0;
    q_next.pslverr = 1'b0;
    // read data and error prepared in the setup cycle
    if (setup) begin
      q_next.pready = 1'b1;
      q_next.prdata = 32'h0000_0000;
      if (hit(i_paddr, `IGC_OFF_FEATURE)) begin
        q_next.prdata = FEATURE_WORD; // R9 R10
      end else if (hit(i_paddr, `IGC_OFF_GLOBAL_CFG)) begin
        q_next.prdata[`IGC_GC_RESET_BIT] =
          (q_reg.rst_state == igc_pkg::IGC_CLR);
        q_next.prdata[`IGC_GC_MODE_BIT]  = 1'b1; // R5
      end else if (hit(i_paddr, `IGC_OFF_SRC0_VP)) begin
        q_next.prdata[`IGC_VP_MASK_BIT] = q_reg.mask;
        q_next.prdata[`IGC_VP_PRIO_LSB +: `IGC_VP_PRIO_W] = q_reg.prio;
        q_next.prdata[`IGC_VP_VEC_W-1:0] = q_reg.vector;
      end else if (hit(i_paddr, `IGC_OFF_SRC0_DEST)) begin
        q_next.prdata[`IGC_NUM_CPUS-1:0] = q_reg.dest;
      end else if (hit(i_paddr, `IGC_OFF_CPU0_INTERRUPT_ACKNOWLEDGE)) begin
        q_next.prdata[`IGC_VP_VEC_W-1:0] = dlv_bus.cpu_int[0] ?
          q_reg.vector : `IGC_SPURIOUS_VEC; // R7
      end else if (hit(i_paddr, `IGC_OFF_CPU1_INTERRUPT_ACKNOWLEDGE)) begin
        q_next.prdata[`IGC_VP_VEC_W-1:0] = dlv_bus.cpu_int[1] ?
          q_reg.vector : `IGC_SPURIOUS_VEC; // R7
      end else if (!hit(i_paddr, `IGC_OFF_CPU0_EOI) &&
                   !hit(i_paddr, `IGC_OFF_CPU1_EOI)) begin
        q_next.pslverr = 1'b1; // unmapped
      end
    end
    // source 0 settings, taken at the completing edge
    if (done && i_pwrite) begin
      if (hit(i_paddr, `IGC_OFF_SRC0_VP)) begin
        q_next.mask   = i_pwdata[`IGC_VP_MASK_BIT];
        q_next.prio   = i_pwdata[`IGC_VP_PRIO_LSB +: `IGC_VP_PRIO_W];
        q_next.vector = i_pwdata[`IGC_VP_VEC_W-1:0];
      end
      if (hit(i_paddr, `IGC_OFF_SRC0_DEST)) begin
        q_next.dest = i_pwdata[`IGC_NUM_CPUS-1:0];
      end
    end
    // soft reset sequence
    unique case (q_reg.rst_state)
      igc_pkg::IGC_RUN: begin
        if (done && i_pwrite && hit(i_paddr, `IGC_OFF_GLOBAL_CFG) &&
            i_pwdata[`IGC_GC_RESET_BIT]) begin
          q_next.rst_state = igc_pkg::IGC_CLR; // R1
          q_next.rst_cnt   = RST_CYCLES - `IGC_RST_CNT_W'(1);
        end
      end
      igc_pkg::IGC_CLR: begin
        q_next.mask   = `IGC_VP_MASK_RST; // R1
        q_next.prio   = `IGC_VP_PRIO_RST;
        q_next.vector = `IGC_VP_VEC_RST;
        q_next.dest   = `IGC_DEST_RST;
        q_next.rst_cnt = q_reg.rst_cnt - `IGC_RST_CNT_W'(1);
        if (q_reg.rst_cnt == '0) begin
          q_next.rst_state = igc_pkg::IGC_RUN; // R2
          q_next.rst_cnt   = '0;
        end
      end
    endcase
  end

  // --------------------------------------------------------------------
  // state register
  // --------------------------------------------------------------------
  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      q_reg           <= '0;
      q_reg.rst_state <= igc_pkg::IGC_RUN;
      q_reg.mask      <= `IGC_VP_MASK_RST;
    end else begin
      q_reg <= q_next;
    end
  end

  // --------------------------------------------------------------------
  // delivery connection
  // --------------------------------------------------------------------
  // cascaded pair on source input 0 feeds the normal delivery path
  assign dlv_bus.src      = i_src0_irq; // R4 R6
  assign dlv_bus.soft_rst = (q_reg.rst_state == igc_pkg::IGC_CLR); // R1
  assign dlv_bus.prio     = q_reg.prio;
  assign dlv_bus.mask     = q_reg.mask;
  assign dlv_bus.dest     = q_reg.dest; // R7
  assign dlv_bus.ack[0]   = done && !i_pwrite &&
                            hit(i_paddr, `IGC_OFF_CPU0_INTERRUPT_ACKNOWLEDGE);
  assign dlv_bus.ack[1]   = done && !i_pwrite &&
                            hit(i_paddr, `IGC_OFF_CPU1_INTERRUPT_ACKNOWLEDGE);
  assign dlv_bus.interrupt_completion[0]   = done && i_pwrite &&
                            hit(i_paddr, `IGC_OFF_CPU0_EOI);
  assign dlv_bus.interrupt_completion[1]   = done && i_pwrite &&
                            hit(i_paddr, `IGC_OFF_CPU1_EOI);

  igc_delivery u_delivery (
    .i_clk   (i_sys_clk),
    .i_rst_n (rst_n),
    .bus     (dlv_bus.dlv)
  );

  // outputs, each a flop except o_ctrl_in_reset, decoded from the reset state
  assign o_pready        = q_reg.pready;
  assign o_pslverr       = q_reg.pslverr;
  assign o_prdata        = q_reg.prdata;
  assign o_cpu_int       = dlv_bus.cpu_int;
  assign o_ctrl_in_reset = (q_reg.rst_state == igc_pkg::IGC_CLR); // R3

  // --------------------------------------------------------------------
  // checks
  // --------------------------------------------------------------------
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!rst_n);

  a_reset_bit_starts: assert property ( // R1
    done && i_pwrite && hit(i_paddr, `IGC_OFF_GLOBAL_CFG) &&
    i_pwdata[`IGC_GC_RESET_BIT] && q_reg.rst_state == igc_pkg::IGC_RUN
    |=> q_reg.rst_state == igc_pkg::IGC_CLR &&
        q_reg.rst_cnt == RST_CYCLES - 1)
    else $error("controller reset did not start");
  a_reset_self_clears: assert property ( // R2
    q_reg.rst_state == igc_pkg::IGC_CLR && q_reg.rst_cnt == 0
    |=> q_reg.rst_state == igc_pkg::IGC_RUN)
    else $error("reset bit did not clear at end of sequence");
  a_mode_reads_one: assert property ( // R5
    setup && hit(i_paddr, `IGC_OFF_GLOBAL_CFG)
    |=> o_prdata[`IGC_GC_MODE_BIT] && o_pready)
    else $error("cascade mode bit not read as one");
  a_feature_word_fixed: assert property ( // R8
    setup && hit(i_paddr, `IGC_OFF_FEATURE)
    |=> o_prdata[7:0] == `IGC_SPEC_VERSION &&
        o_prdata[26:16] == NUM_SOURCES - 1 &&
        o_prdata[12:8] == NUM_CPUS - 1)
    else $error("feature word wrong");
  a_unused_zero: assert property ( // R10
    setup && hit(i_paddr, `IGC_OFF_FEATURE)
    |=> (o_prdata & 32'hF800_E000) == 32'h0)
    else $error("unused feature bits not zero");
  a_cfg_unused_zero: assert property ( // R10
    setup && hit(i_paddr, `IGC_OFF_GLOBAL_CFG)
    |=> (o_prdata & 32'h5FFF_FFFF) == 32'h0)
    else $error("unused configuration bits not zero");
  a_ack_returns_vector: assert property ( // R7
    setup && hit(i_paddr, `IGC_OFF_CPU1_INTERRUPT_ACKNOWLEDGE) && dlv_bus.cpu_int[1]
    |=> o_prdata[7:0] == $past(q_reg.vector) && !o_pslverr)
    else $error("acknowledge did not return source 0 vector");

endmodule

`default_nettype wire

/* test/igc_src_model.sv */
// Purpose: model of the external cascaded interrupt controller pair
// Assumes: request is a level that stays up until the source is served
// Notes:   slow mode adds one cycle of delay before the level changes
`default_nettype none

module igc_src_model (
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  input  wire logic i_raise,
  input  wire logic i_slow,
  output logic      o_src_irq
);
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------
  // request level
  // ----------------------------------------------------------------
  logic stage_reg;

  // level request on source input zero, prompt or one cycle late
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      stage_reg <= 1'b0;
      o_src_irq <= 1'b0;
    end else begin
      stage_reg <= i_raise;
      o_src_irq <= i_slow ? stage_reg : i_raise;
    end
  end
endmodule

`default_nettype wire

/* test/intc_global_config_features_tb.sv */
// Purpose: self-checking bench of the global configuration block
// Assumes: slave answers in one access cycle, as the hand-over says
// Notes:   every register access goes through one transfer task
`include "igc_consts.svh"
`default_nettype none

module intc_global_config_features_tb;
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------
  // signals and expected words
  // ----------------------------------------------------------------
  localparam logic [31:0] FR_EXP  = 32'h000F_0102;
  localparam logic [31:0] GC_IDLE = 32'h2000_0000;
  logic                    clk;
  logic                    arst_n;
  logic                    psel;
  logic                    penable;
  logic                    pwrite;
  logic [`IGC_ADDR_W-1:0]  paddr;
  logic [31:0]             pwdata;
  logic                    raise;
  logic                    slow;
  logic                    src_irq;
  logic                    pready;
  logic                    pslverr;
  logic [31:0]             prdata;
  logic [1:0]              cpu_int;
  logic                    in_reset;
  logic [31:0]             rd;
  logic                    err;
  int                      n;
  int                      n_fail;
  int                      cmp_count;

  igc_top #(.RST_CYCLES(8'h08)) dut (
    .i_sys_clk       (clk),
    .i_arst_n        (arst_n),
    .i_psel          (psel),
    .i_penable       (penable),
    .i_pwrite        (pwrite),
    .i_paddr         (paddr),
    .i_pwdata        (pwdata),
    .i_src0_irq      (src_irq),
    .o_pready        (pready),
    .o_pslverr       (pslverr),
    .o_prdata        (prdata),
    .o_cpu_int       (cpu_int),
    .o_ctrl_in_reset (in_reset)
  );

  igc_src_model src (
    .i_clk     (clk),
    .i_rst_n   (arst_n),
    .i_raise   (raise),
    .i_slow    (slow),
    .o_src_irq (src_irq)
  );

  // ----------------------------------------------------------------
  // clock and helpers
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // prints counts and verdict, then ends the run
  task automatic close_out();
    $display("comparisons %0d, mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  // one bus transfer: setup, then access held until ready is sampled
  task automatic xfer(input logic w, input logic [`IGC_ADDR_W-1:0] a,
                      input logic [31:0] wd);
    int k;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 16);
    if (pready !== 1'b1) begin
      n_fail++;
      $display("unexpected at %0t: no ready", $time);
      close_out();
    end else begin
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
    end
  endtask

  task automatic wr(input logic [`IGC_ADDR_W-1:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
    chk({31'h0, err}, 32'h0);
  endtask

  task automatic rd_chk(input logic [`IGC_ADDR_W-1:0] a,
                        input logic [31:0] exp, input logic exp_err);
    xfer(1'b0, a, 32'h0);
    chk(rd, exp);
    chk({31'h0, err}, {31'h0, exp_err});
  endtask

  // bounded wait for the processor request lines to settle
  task automatic wait_int(input logic [1:0] exp);
    int k;
    k = 0;
    while (cpu_int !== exp && k < 8) begin
      @(posedge clk);
      k++;
    end
    chk({30'h0, cpu_int}, {30'h0, exp});
    if (cpu_int !== exp) begin
      close_out();
    end
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    arst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 18'h00000;
    pwdata = 32'h0;
    raise = 1'b0;
    slow = 1'b0;
    n_fail = 0;
    cmp_count = 0;
    repeat (16) @(posedge clk);
    arst_n <= 1'b1;
    repeat (4) @(posedge clk);
    // fixed words, ignored writes, unmapped place
    rd_chk(`IGC_OFF_FEATURE, FR_EXP, 1'b0);
    wr(`IGC_OFF_FEATURE, 32'hFFFF_FFFF);
    rd_chk(`IGC_OFF_FEATURE, FR_EXP, 1'b0);
    rd_chk(`IGC_OFF_GLOBAL_CFG, GC_IDLE, 1'b0);
    wr(`IGC_OFF_GLOBAL_CFG, 32'h7FFF_FFFF);
    rd_chk(`IGC_OFF_GLOBAL_CFG, GC_IDLE, 1'b0);
    rd_chk(18'h01010, 32'h0, 1'b1);
    $display("test registers done");
    // cascaded request delivered to one processor at a time
    wr(`IGC_OFF_SRC0_VP, 32'h0005_0042);
    for (int c = 1; c >= 0; c--) begin
      slow <= c[0];
      wr(`IGC_OFF_SRC0_DEST, 32'(1 << c));
      raise <= 1'b1;
      wait_int(2'(1 << c));
      rd_chk(c ? `IGC_OFF_CPU0_INTERRUPT_ACKNOWLEDGE : `IGC_OFF_CPU1_INTERRUPT_ACKNOWLEDGE,
             32'h0000_00FF, 1'b0);
      rd_chk(c ? `IGC_OFF_CPU1_INTERRUPT_ACKNOWLEDGE : `IGC_OFF_CPU0_INTERRUPT_ACKNOWLEDGE,
             32'h0000_0042, 1'b0);
      wait_int(2'b00);
      wr(c ? `IGC_OFF_CPU1_EOI : `IGC_OFF_CPU0_EOI, 32'h0);
      wait_int(2'(1 << c));
      raise <= 1'b0;
      wait_int(2'b00);
    end
    $display("test delivery done");
    // source zero settings gate every cascaded request
    wr(`IGC_OFF_SRC0_DEST, 32'h3);
    wr(`IGC_OFF_SRC0_VP, 32'h0000_0042);
    raise <= 1'b1;
    repeat (4) @(posedge clk);
    wait_int(2'b00);
    wr(`IGC_OFF_SRC0_VP, 32'h0005_0042);
    wait_int(2'b11);
    wr(`IGC_OFF_SRC0_VP, 32'h8005_0042);
    wait_int(2'b00);
    wr(`IGC_OFF_SRC0_VP, 32'h0005_0042);
    wait_int(2'b11);
    $display("test settings done");
    // soft reset with a request pending, polled until it ends
    wr(`IGC_OFF_GLOBAL_CFG, 32'h8000_0000);
    @(posedge clk);
    chk({31'h0, in_reset}, 32'h1);
    rd_chk(`IGC_OFF_GLOBAL_CFG, 32'hA000_0000, 1'b0);
    n = 0;
    while (rd[31] === 1'b1 && n < 20) begin
      xfer(1'b0, `IGC_OFF_GLOBAL_CFG, 32'h0);
      n++;
    end
    chk(rd, GC_IDLE);
    if (rd[31] !== 1'b0) begin
      close_out();
    end
    chk({31'h0, in_reset}, 32'h0);
    rd_chk(`IGC_OFF_SRC0_VP, 32'h8000_0000, 1'b0);
    rd_chk(`IGC_OFF_SRC0_DEST, 32'h0, 1'b0);
    wait_int(2'b00);
    rd_chk(`IGC_OFF_CPU1_INTERRUPT_ACKNOWLEDGE, 32'h0000_00FF, 1'b0);
    raise <= 1'b0;
    $display("test soft reset done");
    close_out();
  end
endmodule

`default_nettype wire
